//--- dv/fsrcd_link_checker.sv
// Purpose: link checks between the host end and the status register decoder
// Assumes: host flops drive cs_b, sclk and mosi from clk; DIV matches the host
// Notes:   device events are seen one clk sample after the sclk edge
`timescale 1ns/1ps
module fsrcd_link_checker #(
  parameter int DIV = 4
) (
  // system
  input wire logic clk,
  input wire logic rst_b,
  // link
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  // ---------------------------------------------------------------
  // frame tracking
  // ---------------------------------------------------------------
  logic       sclk_reg, sclk_next, rise, rd_op;
  logic [6:0] rise_reg, rise_next;
  logic [7:0] sh_reg, sh_next, op_reg, op_next;
  logic [9:0] oe_reg, oe_next;

  always_comb begin
    rise      = sclk & ~sclk_reg;
    sclk_next = sclk;
    sh_next   = rise ? {sh_reg[6:0], mosi} : sh_reg;
    op_next   = (rise && rise_reg == 7'h07) ? sh_next : op_reg;
    rise_next = cs_b ? 7'h00 : rise_reg + {6'h00, rise};
    oe_next   = miso_oe ? oe_reg + 10'h001 : 10'h000;
    rd_op     = op_reg inside {fsrcd_pkg::OP_RD_SR1, fsrcd_pkg::OP_RD_SR2, fsrcd_pkg::OP_RD_SR3,
                               fsrcd_pkg::OP_RD_SRX};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_reg <= 1'b0;
      rise_reg <= 7'h00;
      sh_reg   <= 8'h00;
      op_reg   <= 8'h00;
      oe_reg   <= 10'h000;
    end else begin
      sclk_reg <= sclk_next;
      rise_reg <= rise_next;
      sh_reg   <= sh_next;
      op_reg   <= op_next;
      oe_reg   <= oe_next;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_sclk_in_frame: assert property (sclk |-> !cs_b)
    else $error("link clock high outside a frame");
  a_cs_to_sclk: assert property ($fell(cs_b) |-> !sclk ##DIV $rose(sclk))
    else $error("first link clock rise misplaced");
  a_mosi_held: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved while link clock high");
  a_miso_at_fall: assert property ($changed(miso) |-> $fell(sclk) || $rose(cs_b))
    else $error("device data moved off a falling edge");
  a_oe_after_hdr: assert property ($rose(miso_oe) |->
    (op_reg == fsrcd_pkg::OP_RD_SRX ? rise_reg == 7'h18 : rise_reg == 7'h08))
    else $error("read data began at the wrong bit count");
  a_oe_byte_end: assert property ($fell(miso_oe) |-> rise_reg[2:0] == 3'h0 && rise_reg >= 7'h10)
    else $error("read data ended inside a byte");
  a_oe_span: assert property ($fell(miso_oe) |-> oe_reg != 10'h000 && oe_reg % (16 * DIV) == 0)
    else $error("read data span not whole bytes");
  a_oe_no_write: assert property (rise_reg >= 7'h08 && !rd_op |-> !miso_oe)
    else $error("device drove data for a non-read opcode");
endmodule

//--- dv/tb_flash_status_reg_cmd_decoder.sv
// Purpose: host and device joined on one link, driven from the host request side
// Assumes: DIV of 4 gives a 160 ns link clock from the 20 ns system clock
// Notes:   expected register image is tracked here from the commands sent
`timescale 1ns/1ps
module tb_flash_status_reg_cmd_decoder;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk, rst_b, start, busy, done, rd_valid, stat_upd;
  logic [7:0]  op, addr, rdata, fb;
  logic [15:0] wdata;
  logic [2:0]  n_data;
  logic [39:0] stat_q, exp_sr;
  logic [7:0]  rq[$];
  int          n_fail, comparisons, nbits, n_upd, u, n_oe, v;

  fsrcd_if link();
  fsrcd_host #(.DIV(4)) u_fsrcd_host (.clk(clk), .rst_b(rst_b), .start(start), .op(op), .addr(addr),
    .wdata(wdata), .n_data(n_data), .busy(busy), .done(done), .rdata(rdata), .rd_valid(rd_valid),
    .link(link));
  fsrcd_device u_fsrcd_device (.clk(clk), .rst_b(rst_b), .stat_q(stat_q), .stat_upd(stat_upd), .link(link));
  fsrcd_link_checker #(.DIV(4)) u_fsrcd_link_checker (.clk(clk), .rst_b(rst_b), .cs_b(link.cs_b),
    .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  // ---------------------------------------------------------------
  // monitors: read bytes, update pulses, first byte seen on the wire
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (rd_valid === 1'b1) rq.push_back(rdata);
    if (stat_upd === 1'b1) n_upd++;
    // the host reads miso blindly, so device drive is counted on the wire
    if (link.miso_oe === 1'b1) n_oe++;
  end

  always @(posedge link.sclk or posedge link.cs_b) begin
    if (link.cs_b) nbits = 0;
    else if (nbits < 8) begin
      fb = {fb[6:0], link.mosi};
      nbits++;
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic run(input logic [7:0] o, input logic [7:0] a, input logic [15:0] w, input logic [2:0] n);
    int k;
    rq.delete();
    @(posedge clk);
    start  <= 1'b1;
    op     <= o;
    addr   <= a;
    wdata  <= w;
    n_data <= n;
    @(posedge clk);
    start <= 1'b0;
    #1;
    chk(40'(busy), 40'h1);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 3000);
    if (k >= 3000) begin
      n_fail++;
      $display("ERROR t=%0t frame never completed", $time);
    end
    chk(40'(busy), 40'h0);
    chk(40'(fb), 40'(o));
    // status crossing needs a few clk cycles after the writing edge
    repeat (8) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] o, input logic [7:0] a, input logic [15:0] w, input logic [2:0] n);
    run(o, a, w, n);
    chk(stat_q, exp_sr);
  endtask

  task automatic rd(input logic [7:0] o, input logic [7:0] a, input logic [7:0] e);
    run(o, a, 16'h0000, 3'h1);
    chk(40'(rq.size()), 40'h1);
    chk(40'(rq[0]), 40'(e));
  endtask

  task automatic end_of_test();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0; start = 1'b0; op = 8'h00; addr = 8'h00; wdata = 16'h0000; n_data = 3'h1;
    exp_sr = 40'h0; fb = 8'h00; nbits = 0; n_upd = 0; n_fail = 0; comparisons = 0; n_oe = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(fsrcd_pkg::OP_RD_SR1, 8'h00, fsrcd_pkg::SR_RESET);
    exp_sr[7:0] = 8'ha5;
    wr(fsrcd_pkg::OP_WR_SR1, 8'h00, 16'ha500, 3'h1);
    exp_sr[15:8] = 8'h3c;
    wr(fsrcd_pkg::OP_WR_SR2, 8'h00, 16'h3c00, 3'h1);
    exp_sr[23:16] = 8'h81;
    wr(fsrcd_pkg::OP_WR_SR3, 8'h00, 16'h8100, 3'h1);
    exp_sr[31:24] = 8'h5a;
    wr(fsrcd_pkg::OP_WR_SRX, 8'h04, 16'h5a00, 3'h1);
    exp_sr[39:32] = 8'hc3;
    wr(fsrcd_pkg::OP_WR_SRX, 8'h05, 16'hc300, 3'h1);
    chk(40'(n_upd), 40'h5);
    $display("test writes done");
    rd(fsrcd_pkg::OP_RD_SR1, 8'h00, 8'ha5);
    rd(fsrcd_pkg::OP_RD_SR2, 8'h00, 8'h3c);
    rd(fsrcd_pkg::OP_RD_SR3, 8'h00, 8'h81);
    rd(fsrcd_pkg::OP_RD_SRX, 8'h04, 8'h5a);
    rd(fsrcd_pkg::OP_RD_SRX, 8'h05, 8'hc3);
    rd(fsrcd_pkg::OP_RD_SRX, 8'h02, 8'h3c);
    $display("test reads done");
    run(fsrcd_pkg::OP_RD_SRX, fsrcd_pkg::ADDR_BURST, 16'h0000, 3'h5);
    chk(40'(rq.size()), 40'h5);
    for (int i = 0; i < 5; i++) chk(40'(rq[i]), 40'(exp_sr[8*i +: 8]));
    $display("test burst done");
    exp_sr[15:0] = 16'h2d1e;
    wr(fsrcd_pkg::OP_WR_SR1, 8'h00, 16'h1e2d, 3'h2);
    $display("test legacy done");
    u = n_upd;
    v = n_oe;
    // bytes after the bad opcode form a valid write that must stay ignored
    wr(8'ha7, 8'h00, 16'h01ff, 3'h2);
    chk(40'(rq.size()), 40'h0);
    chk(40'(n_oe - v), 40'h0);
    wr(fsrcd_pkg::OP_WR_SRX, 8'h06, 16'hffff, 3'h1);
    chk(40'(n_upd - u), 40'h0);
    // the host still returns one byte; the device must not drive it
    run(fsrcd_pkg::OP_RD_SRX, 8'h06, 16'h0000, 3'h1);
    chk(40'(rq.size()), 40'h1);
    chk(40'(n_oe - v), 40'h0);
    rd(fsrcd_pkg::OP_RD_SR1, 8'h00, 8'h1e);
    $display("test refusals done");
    end_of_test();
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    $display("ERROR t=%0t watchdog expired", $time);
    end_of_test();
  end
endmodule

//--- rtl/fsrcd_device.sv
// Purpose: device end; decodes status register read and write commands
// Assumes: link clock idles low, frames bounded by chip select
// Notes:   frame logic runs on sclk and is held reset while chip select is high
//
// How it works
// [RL1] 05h reads status register 1, no address
// [RL2] 35h reads status register 2, no address
// [RL3] 15h reads status register 3, no address
// [RL4] 65h, address, dummy, then one output byte
// [RL5] 65h with address 05h reads register 5
// [RL6] 01h plus one byte writes register 1
// [RL7] 31h plus one byte writes register 2
// [RL8] 11h plus one byte writes register 3
// [RL9] 71h, address, one data byte, no dummy
// [RL10] 71h with address 05h writes register 5
// [RL11] all bytes shift most significant bit first
// [RL12] unknown opcode ignored until chip select cycles
// [RL13] 65h from address 01h streams all five
// [RL14] 01h second data byte writes register 2
// [RL15] address byte is register index 1 to 5
`timescale 1ns/1ps
module fsrcd_device (
  // system
  input  wire logic        clk,
  input  wire logic        rst_b,
  // status register image in the clk domain
  output logic [39:0]      stat_q,
  output logic             stat_upd,
  // link
  fsrcd_if.device          link
);

  typedef enum logic [2:0] {
    ST_CMD   = 3'b000,
    ST_ADDR  = 3'b001,
    ST_DUMMY = 3'b011,
    ST_RD    = 3'b010,
    ST_WR    = 3'b110,
    ST_SKIP  = 3'b100
  } fsrcd_st_e;

  fsrcd_st_e  st_reg, st_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [6:0] rx_reg, rx_next;
  logic [2:0] idx_reg, idx_next;
  logic       rdx_reg, rdx_next;
  logic       burst_reg, burst_next;
  logic       legacy_reg, legacy_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] sr_reg [1:5];
  logic [7:0] sr_next [1:5];
  logic       tgl_reg, tgl_next;
  logic       miso_reg, miso_next, oe_reg, oe_next;
  logic [7:0] in_byte;
  logic       byte_done;
  logic       frame_rst_b;
  logic       tgl_s1, tgl_s2, tgl_s3;
  logic [39:0] stat_next;
  logic       upd_next;

  // chip select high holds the frame logic in reset, so any partial
  // command or ignored frame is dropped without needing an sclk edge
  assign frame_rst_b = rst_b & ~link.cs_b; // RL12

  assign in_byte   = {rx_reg, link.mosi}; // RL11
  assign byte_done = (cnt_reg == 3'h7);

  // ---------------------------------------------------------------
  // frame decoder, rising edge of the link clock
  // ---------------------------------------------------------------
  always_comb begin
    st_next     = st_reg;
    cnt_next    = cnt_reg + 3'h1;
    rx_next     = in_byte[6:0];
    idx_next    = idx_reg;
    rdx_next    = rdx_reg;
    burst_next  = burst_reg;
    legacy_next = legacy_reg;
    tx_next     = tx_reg;
    tgl_next    = tgl_reg;
    for (int i = 1; i <= fsrcd_pkg::SR_COUNT; i++) begin
      sr_next[i] = sr_reg[i];
    end
    if (byte_done) begin
      case (st_reg)
        ST_CMD: begin
          case (in_byte)
            fsrcd_pkg::OP_RD_SR1: begin
              idx_next = fsrcd_pkg::IDX_SR1; // RL1
              tx_next  = sr_reg[fsrcd_pkg::IDX_SR1];
              st_next  = ST_RD;
            end
            fsrcd_pkg::OP_RD_SR2: begin
              idx_next = fsrcd_pkg::IDX_SR2; // RL2
              tx_next  = sr_reg[fsrcd_pkg::IDX_SR2];
              st_next  = ST_RD;
            end
            fsrcd_pkg::OP_RD_SR3: begin
              idx_next = fsrcd_pkg::IDX_SR3; // RL3
              tx_next  = sr_reg[fsrcd_pkg::IDX_SR3];
              st_next  = ST_RD;
            end
            fsrcd_pkg::OP_WR_SR1: begin
              idx_next    = fsrcd_pkg::IDX_SR1; // RL6
              legacy_next = 1'b1; // RL14
              st_next     = ST_WR;
            end
            fsrcd_pkg::OP_WR_SR2: begin
              idx_next = fsrcd_pkg::IDX_SR2; // RL7
              st_next  = ST_WR;
            end
            fsrcd_pkg::OP_WR_SR3: begin
              idx_next = fsrcd_pkg::IDX_SR3; // RL8
              st_next  = ST_WR;
            end
            fsrcd_pkg::OP_RD_SRX: begin
              rdx_next = 1'b1; // RL4
              st_next  = ST_ADDR;
            end
            fsrcd_pkg::OP_WR_SRX: begin
              rdx_next = 1'b0; // RL9
              st_next  = ST_ADDR;
            end
            default: st_next = ST_SKIP; // RL12
          endcase
        end
        ST_ADDR: begin
          // an index outside 1..5 selects nothing, so the frame is ignored
          if (in_byte >= 8'(fsrcd_pkg::IDX_SR1) && in_byte <= 8'(fsrcd_pkg::IDX_SR5)) begin
            idx_next   = in_byte[2:0]; // RL15
            burst_next = rdx_reg && (in_byte == fsrcd_pkg::ADDR_BURST); // RL13
            st_next    = rdx_reg ? ST_DUMMY : ST_WR; // RL4 RL9 RL5 RL10
          end else begin
            st_next = ST_SKIP;
          end
        end
        ST_DUMMY: begin
          tx_next = sr_reg[idx_reg]; // RL4 RL5
          st_next = ST_RD;
        end
        ST_RD: begin
          if (burst_reg && idx_reg != fsrcd_pkg::IDX_SR5) begin
            idx_next = idx_reg + 3'h1; // RL13
            tx_next  = sr_reg[idx_reg + 3'h1];
          end else begin
            st_next = ST_SKIP;
          end
        end
        ST_WR: begin
          sr_next[idx_reg] = in_byte; // RL6 RL7 RL8 RL9 RL10
          tgl_next         = !tgl_reg;
          if (legacy_reg) begin
            legacy_next = 1'b0; // RL14
            idx_next    = fsrcd_pkg::IDX_SR2;
          end else begin
            st_next = ST_SKIP;
          end
        end
        ST_SKIP: st_next = ST_SKIP; // RL12
        default: st_next = ST_SKIP;
      endcase
    end
  end

  always_ff @(posedge link.sclk or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      st_reg     <= ST_CMD;
      cnt_reg    <= 3'h0;
      rx_reg     <= 7'h00;
      idx_reg    <= 3'h0;
      rdx_reg    <= 1'b0;
      burst_reg  <= 1'b0;
      legacy_reg <= 1'b0;
      tx_reg     <= 8'h00;
    end else begin
      st_reg     <= st_next;
      cnt_reg    <= cnt_next;
      rx_reg     <= rx_next;
      idx_reg    <= idx_next;
      rdx_reg    <= rdx_next;
      burst_reg  <= burst_next;
      legacy_reg <= legacy_next;
      tx_reg     <= tx_next;
    end
  end

  // status contents survive chip select, so only the system reset clears them
  always_ff @(posedge link.sclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 1; i <= fsrcd_pkg::SR_COUNT; i++) begin
        sr_reg[i] <= fsrcd_pkg::SR_RESET;
      end
      tgl_reg <= 1'b0;
    end else begin
      for (int i = 1; i <= fsrcd_pkg::SR_COUNT; i++) begin
        sr_reg[i] <= sr_next[i];
      end
      tgl_reg <= tgl_next;
    end
  end

  // ---------------------------------------------------------------
  // output shifter, falling edge of the link clock
  // ---------------------------------------------------------------
  always_comb begin
    oe_next   = (st_reg == ST_RD);
    miso_next = oe_next ? tx_reg[3'h7 - cnt_reg] : 1'b0; // RL11
  end

  always_ff @(negedge link.sclk or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      miso_reg <= 1'b0;
      oe_reg   <= 1'b0;
    end else begin
      miso_reg <= miso_next;
      oe_reg   <= oe_next;
    end
  end

  assign link.miso    = miso_reg;
  assign link.miso_oe = oe_reg;

  // ---------------------------------------------------------------
  // crossing to clk: toggle synchroniser, data sampled once settled
  // ---------------------------------------------------------------
  // the array is only read after the toggle has passed two flops; a new
  // write needs at least eight link clocks, far longer than the sync delay
  always_comb begin
    upd_next  = tgl_s2 ^ tgl_s3;
    stat_next = stat_q;
    if (upd_next) begin
      stat_next = {sr_reg[5], sr_reg[4], sr_reg[3], sr_reg[2], sr_reg[1]};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_s1   <= 1'b0;
      tgl_s2   <= 1'b0;
      tgl_s3   <= 1'b0;
      stat_q   <= {5{fsrcd_pkg::SR_RESET}};
      stat_upd <= 1'b0;
    end else begin
      tgl_s1   <= tgl_reg;
      tgl_s2   <= tgl_s1;
      tgl_s3   <= tgl_s2;
      stat_q   <= stat_next;
      stat_upd <= upd_next;
    end
  end

endmodule

//--- rtl/fsrcd_host.sv
// Purpose: host end; frames one status register command on the link
// Assumes: half period of the link clock is DIV clk cycles, DIV at least 3
// Notes:   miso is sampled through two flops just before each falling edge
`timescale 1ns/1ps
module fsrcd_host #(
  parameter int DIV = 4
) (
  // system
  input  wire logic        clk,
  input  wire logic        rst_b,
  // command request
  input  wire logic        start,
  input  wire logic [7:0]  op,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic [2:0]  n_data,
  output logic             busy,
  output logic             done,
  // read answer
  output logic [7:0]       rdata,
  output logic             rd_valid,
  // link
  fsrcd_if.host            link
);

  typedef enum logic [1:0] {H_IDLE = 2'b00, H_RUN = 2'b01, H_END = 2'b11} fsrcd_hst_e;

  fsrcd_hst_e  st_reg, st_next;
  logic [7:0]  div_reg, div_next;
  logic        sclk_reg, sclk_next, cs_b_reg, cs_b_next, mosi_reg, mosi_next;
  logic [2:0]  bit_reg, bit_next;
  logic [2:0]  byte_reg, byte_next, last_reg, last_next, head_reg, head_next;
  logic [7:0]  tx_reg, tx_next, rx_reg, rx_next, op_reg, op_next, addr_reg, addr_next;
  logic [15:0] wd_reg, wd_next;
  logic [7:0]  rdata_next;
  logic        rdv_next, done_next, busy_next;
  logic        miso_s1, miso_s2;
  logic [7:0]  nb;

  // ---------------------------------------------------------------
  // byte sequence: command, address, dummy, data
  // ---------------------------------------------------------------
  function automatic logic [7:0] byte_at(input logic [2:0] i, input logic [2:0] hd,
                                         input logic [7:0] o, input logic [7:0] a,
                                         input logic [15:0] w);
    logic [7:0] r;
    r = fsrcd_pkg::DUMMY_BYTE;
    if (i == 3'h1 && fsrcd_pkg::fsrcd_has_addr(o)) begin // RL4 RL9
      r = a;
    end else if (i >= hd && !fsrcd_pkg::fsrcd_is_read(o)) begin
      r = (i == hd) ? w[15:8] : w[7:0]; // RL14
    end
    return r;
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      miso_s1 <= link.miso;
      miso_s2 <= miso_s1;
    end
  end

  always_comb begin
    st_next    = st_reg;
    div_next   = div_reg;
    sclk_next  = sclk_reg;
    cs_b_next  = cs_b_reg;
    mosi_next  = mosi_reg;
    bit_next   = bit_reg;
    byte_next  = byte_reg;
    last_next  = last_reg;
    head_next  = head_reg;
    tx_next    = tx_reg;
    rx_next    = rx_reg;
    op_next    = op_reg;
    addr_next  = addr_reg;
    wd_next    = wd_reg;
    rdata_next = rdata;
    rdv_next   = 1'b0;
    done_next  = 1'b0;
    busy_next  = busy;
    nb         = fsrcd_pkg::DUMMY_BYTE;
    case (st_reg)
      H_IDLE: begin
        if (start) begin
          head_next = 3'(1 + int'(fsrcd_pkg::fsrcd_has_addr(op)) + int'(fsrcd_pkg::fsrcd_has_dummy(op)));
          last_next = 3'(head_next + n_data - 3'h1);
          op_next   = op;
          addr_next = addr;
          wd_next   = wdata;
          tx_next   = op;
          mosi_next = op[7]; // RL11
          cs_b_next = 1'b0;
          div_next  = 8'h00;
          bit_next  = 3'h0;
          byte_next = 3'h0;
          busy_next = 1'b1;
          st_next   = H_RUN;
        end
      end
      H_RUN: begin
        div_next = div_reg + 8'h01;
        if (div_reg == 8'(DIV - 1)) begin
          div_next  = 8'h00;
          sclk_next = !sclk_reg;
          if (sclk_reg) begin
            rx_next  = {rx_reg[6:0], miso_s2};
            bit_next = bit_reg + 3'h1;
            tx_next  = {tx_reg[6:0], 1'b0};
            mosi_next = tx_reg[6];
            if (bit_reg == 3'h7) begin
              if (byte_reg >= head_reg && fsrcd_pkg::fsrcd_is_read(op_reg)) begin
                rdata_next = {rx_reg[6:0], miso_s2};
                rdv_next   = 1'b1;
              end
              byte_next = byte_reg + 3'h1;
              nb        = byte_at(byte_next, head_reg, op_reg, addr_reg, wd_reg);
              tx_next   = nb;
              mosi_next = nb[7];
              if (byte_reg == last_reg) begin
                mosi_next = 1'b0;
                st_next   = H_END;
              end
            end
          end
        end
      end
      H_END: begin
        div_next = div_reg + 8'h01;
        if (div_reg == 8'(DIV - 1)) begin
          cs_b_next = 1'b1;
          done_next = 1'b1;
          busy_next = 1'b0;
          st_next   = H_IDLE;
        end
      end
      default: st_next = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg   <= H_IDLE;
      div_reg  <= 8'h00;
      sclk_reg <= 1'b0;
      cs_b_reg <= 1'b1;
      mosi_reg <= 1'b0;
      bit_reg  <= 3'h0;
      byte_reg <= 3'h0;
      last_reg <= 3'h0;
      head_reg <= 3'h0;
      tx_reg   <= 8'h00;
      rx_reg   <= 8'h00;
      op_reg   <= 8'h00;
      addr_reg <= 8'h00;
      wd_reg   <= 16'h0000;
      rdata    <= 8'h00;
      rd_valid <= 1'b0;
      done     <= 1'b0;
      busy     <= 1'b0;
    end else begin
      st_reg   <= st_next;
      div_reg  <= div_next;
      sclk_reg <= sclk_next;
      cs_b_reg <= cs_b_next;
      mosi_reg <= mosi_next;
      bit_reg  <= bit_next;
      byte_reg <= byte_next;
      last_reg <= last_next;
      head_reg <= head_next;
      tx_reg   <= tx_next;
      rx_reg   <= rx_next;
      op_reg   <= op_next;
      addr_reg <= addr_next;
      wd_reg   <= wd_next;
      rdata    <= rdata_next;
      rd_valid <= rdv_next;
      done     <= done_next;
      busy     <= busy_next;
    end
  end

  assign link.sclk = sclk_reg;
  assign link.cs_b = cs_b_reg;
  assign link.mosi = mosi_reg;

endmodule

//--- shared/fsrcd_if.sv
// Purpose: serial link between host controller and status register decoder
// Assumes: the device holds miso low whenever miso_oe is low
// Notes:   clock idles low; host drives on falling, device samples on rising
`timescale 1ns/1ps
interface fsrcd_if;
  logic cs_b;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport device (
    input  cs_b,
    input  sclk,
    input  mosi,
    output miso,
    output miso_oe
  );

  modport host (
    output cs_b,
    output sclk,
    output mosi,
    input  miso,
    input  miso_oe
  );
endinterface

//--- shared/fsrcd_pkg.sv
// Purpose: constants for the status register command decoder and its host
// Assumes: single-line serial link, msb first, idle clock low
// Notes:   opcode helpers give the host its frame shape; the device decodes opcodes itself
package fsrcd_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_RD_SR1  = 8'h05;
  localparam logic [7:0] OP_RD_SR2  = 8'h35;
  localparam logic [7:0] OP_RD_SR3  = 8'h15;
  localparam logic [7:0] OP_RD_SRX  = 8'h65;
  localparam logic [7:0] OP_WR_SR1  = 8'h01;
  localparam logic [7:0] OP_WR_SR2  = 8'h31;
  localparam logic [7:0] OP_WR_SR3  = 8'h11;
  localparam logic [7:0] OP_WR_SRX  = 8'h71;

  // ---------------------------------------------------------------
  // register indices and reset values
  // ---------------------------------------------------------------
  localparam int         SR_COUNT   = 5;
  localparam logic [2:0] IDX_SR1    = 3'h1;
  localparam logic [2:0] IDX_SR2    = 3'h2;
  localparam logic [2:0] IDX_SR3    = 3'h3;
  localparam logic [2:0] IDX_SR4    = 3'h4;
  localparam logic [2:0] IDX_SR5    = 3'h5;
  localparam logic [7:0] ADDR_BURST = 8'h01;
  localparam logic [7:0] SR_RESET   = 8'h00;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // frame shape helpers
  // ---------------------------------------------------------------
  function automatic logic fsrcd_has_addr(input logic [7:0] op);
    return (op == OP_RD_SRX) || (op == OP_WR_SRX);
  endfunction

  function automatic logic fsrcd_has_dummy(input logic [7:0] op);
    return op == OP_RD_SRX;
  endfunction

  function automatic logic fsrcd_is_read(input logic [7:0] op);
    return (op == OP_RD_SR1) || (op == OP_RD_SR2) || (op == OP_RD_SR3) || (op == OP_RD_SRX);
  endfunction

endpackage
